// ===== rtl/cra_responder.v
// Purpose: Decodes config access messages and returns status replies.
// Assumes: Token stream comes from logic on clk_sys; no synchroniser needed.
// Notes:   Multi-byte fields arrive and leave most significant byte first.
`timescale 1ns/1ps
`include "cra_map.vh"
module cra_responder (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// Incoming request tokens
	input  wire        inValid,
	output wire        inReady,
	input  wire [7:0]  inData,
	input  wire        inCtrl,
	input  wire [31:0] chanDest,
	// Outgoing reply tokens
	output wire        outValid,
	input  wire        outReady,
	output wire [7:0]  outData,
	output wire        outCtrl,
	output wire [23:0] outDest
);
	localparam S_IDLE  = 3'h0;
	localparam S_RID   = 3'h1;
	localparam S_REG   = 3'h2;
	localparam S_SIZE  = 3'h3;
	localparam S_DATA  = 3'h4;
	localparam S_END   = 3'h5;
	localparam S_DRAIN = 3'h6;
	localparam S_RESP  = 3'h7;

	reg  [2:0]  state_r;
	reg  [1:0]  kind_r;
	reg  [7:0]  cnt_r;
	reg  [31:0] word_r;
	reg  [23:0] rid_r;
	reg  [23:0] dest_r;
	reg  [15:0] regNum_r;
	reg  [7:0]  size_r;
	reg         bad_r;
	reg         hasRid_r;
	reg         start_r;
	reg         respOk_r;
	reg  [7:0]  respCnt_r;
	reg  [31:0] cfgMem [0:(1<<`CRA_CFG_AW)-1];
	reg  [7:0]  perMem [0:(1<<`CRA_PER_AW)-1];
	reg  [7:0]  byteSel;
	wire [7:0]  byteIdx;
	wire        txBusy;
	wire        accept;
	wire        isEnd;
	wire        isPer;
	wire        cfgOk;
	wire        perOk;
	wire        regOk;
	wire [8:0]  perTop;
	wire [`CRA_PER_AW-1:0] perWrIdx;
	wire [`CRA_PER_AW-1:0] perRdIdx;
	wire [31:0] cfgWord;
	wire        destCfg;
	wire        destPer;

	assign inReady = (state_r != S_RESP);
	assign accept  = inValid && inReady;
	assign isEnd   = inCtrl && (inData == `CRA_TOK_END);
	assign isPer   = kind_r[1];
	assign outDest = dest_r;
	assign destCfg = (chanDest[15:0] == `CRA_DST_TILE) ||
			 (chanDest[15:0] == `CRA_DST_NODE);
	assign destPer = (chanDest[7:0] == `CRA_DST_PER);
	assign perTop  = {1'b0, regNum_r[7:0]} + {1'b0, size_r};
	assign cfgOk   = (regNum_r < `CRA_CFG_REGS);
	// A zero-length peripheral read is refused as meaningless.
	assign perOk   = (perTop <= `CRA_PER_BYTES) &&
			 (size_r != 8'h00 || kind_r == `CRA_KIND_PWR);
	assign regOk   = isPer ? perOk : cfgOk;
	assign perWrIdx = regNum_r[`CRA_PER_AW-1:0] + cnt_r[`CRA_PER_AW-1:0];
	assign perRdIdx = regNum_r[`CRA_PER_AW-1:0] + byteIdx[`CRA_PER_AW-1:0];
	assign cfgWord = cfgMem[regNum_r[`CRA_CFG_AW-1:0]];

	// Reply byte source; memories are frozen while a reply is sent.
	always @* begin
		byteSel = perMem[perRdIdx];
		if (!isPer) begin
			case (byteIdx[1:0])
			2'h0: byteSel = cfgWord[31:24];
			2'h1: byteSel = cfgWord[23:16];
			2'h2: byteSel = cfgWord[15:8];
			default: byteSel = cfgWord[7:0];
			endcase
		end
	end

	// Memory writes carry no reset so that contents survive a soft reset.
	always @(posedge clk_sys) begin
		if (!rst && state_r == S_END && accept && isEnd && !bad_r &&
		    cfgOk && kind_r == `CRA_KIND_WR)
			cfgMem[regNum_r[`CRA_CFG_AW-1:0]] <= word_r;
		if (!rst && state_r == S_DATA && accept && !inCtrl && isPer &&
		    !bad_r && perOk)
			perMem[perWrIdx] <= inData;
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			state_r   <= S_IDLE;
			kind_r    <= `CRA_KIND_WR;
			cnt_r     <= 8'h00;
			word_r    <= 32'h00000000;
			rid_r     <= 24'h000000;
			dest_r    <= 24'h000000;
			regNum_r  <= 16'h0000;
			size_r    <= 8'h00;
			bad_r     <= 1'b0;
			hasRid_r  <= 1'b0;
			start_r   <= 1'b0;
			respOk_r  <= 1'b0;
			respCnt_r <= 8'h00;
		end else begin
			start_r <= 1'b0;
			if (accept && state_r != S_IDLE && state_r != S_END &&
			    state_r != S_DRAIN && inCtrl) begin
				bad_r <= 1'b1;
				state_r <= isEnd ? (hasRid_r ? S_RESP : S_IDLE)
						 : S_DRAIN;
				start_r <= isEnd && hasRid_r;
				respOk_r <= 1'b0;
				respCnt_r <= 8'h00;
				dest_r <= rid_r;
			end else begin
				case (state_r)
				S_IDLE: begin
					cnt_r    <= 8'h00;
					hasRid_r <= 1'b0;
					bad_r    <= 1'b0;
					regNum_r <= 16'h0000;
					size_r   <= 8'h00;
					if (accept) begin
						state_r <= S_RID;
						if (inCtrl && inData == `CRA_TOK_WR) begin
							kind_r <= `CRA_KIND_WR;
							bad_r  <= !destCfg;
						end else if (inCtrl && inData == `CRA_TOK_RD) begin
							kind_r <= `CRA_KIND_RD;
							bad_r  <= !destCfg;
						end else if (inCtrl && inData == `CRA_TOK_PRD) begin
							kind_r <= `CRA_KIND_PRD;
							bad_r  <= !destPer;
						end else if (inCtrl && inData == `CRA_TOK_PWR) begin
							kind_r <= `CRA_KIND_PWR;
							bad_r  <= !destPer;
						end else if (!isEnd) begin
							// No return id yet, so it is dropped silently.
							state_r <= S_DRAIN;
						end else begin
							state_r <= S_IDLE;
						end
					end
				end
				S_RID: begin
					if (accept) begin
						rid_r <= {rid_r[15:0], inData};
						cnt_r <= cnt_r + 8'h01;
						if (cnt_r == `CRA_RID_LAST) begin
							hasRid_r <= 1'b1;
							state_r  <= S_REG;
							cnt_r    <= 8'h00;
						end
					end
				end
				S_REG: begin
					if (accept) begin
						regNum_r <= {regNum_r[7:0], inData};
						cnt_r    <= cnt_r + 8'h01;
						if (isPer) begin
							state_r <= S_SIZE;
							cnt_r   <= 8'h00;
						end else if (cnt_r != 8'h00) begin
							cnt_r   <= 8'h00;
							state_r <= (kind_r == `CRA_KIND_WR) ?
								   S_DATA : S_END;
						end
					end
				end
				S_SIZE: begin
					if (accept) begin
						size_r  <= inData;
						state_r <= (kind_r == `CRA_KIND_PWR &&
							    inData != 8'h00) ? S_DATA : S_END;
					end
				end
				S_DATA: begin
					if (accept) begin
						word_r <= {word_r[23:0], inData};
						cnt_r  <= cnt_r + 8'h01;
						if ((isPer && cnt_r + 8'h01 == size_r) ||
						    (!isPer && cnt_r == `CRA_WORD_LAST))
							state_r <= S_END;
					end
				end
				S_END: begin
					if (accept) begin
						if (isEnd) begin
							state_r   <= S_RESP;
							start_r   <= 1'b1;
							dest_r    <= rid_r;
							respOk_r  <= !bad_r && regOk;
							if (kind_r == `CRA_KIND_RD)
								respCnt_r <= `CRA_WORD_BYTES;
							else if (kind_r == `CRA_KIND_PRD)
								respCnt_r <= size_r;
							else
								respCnt_r <= 8'h00;
						end else begin
							// Surplus tokens make the request malformed.
							bad_r   <= 1'b1;
							state_r <= S_DRAIN;
						end
					end
				end
				S_DRAIN: begin
					if (accept && isEnd) begin
						state_r   <= hasRid_r ? S_RESP : S_IDLE;
						start_r   <= hasRid_r;
						dest_r    <= rid_r;
						respOk_r  <= 1'b0;
						respCnt_r <= 8'h00;
					end
				end
				S_RESP: begin
					if (!start_r && !txBusy)
						state_r <= S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
				endcase
			end
		end
	end

	cra_resp_tx u_tx (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.start    (start_r),
		.okFlag   (respOk_r),
		.dataCnt  (respCnt_r),
		.byteIdx  (byteIdx),
		.byteIn   (byteSel),
		.busy     (txBusy),
		.outValid (outValid),
		.outReady (outReady),
		.outData  (outData),
		.outCtrl  (outCtrl)
	);
endmodule

// ===== rtl/cra_map.vh
// Purpose: Token codes, address patterns and sizes for the config responder.
// Assumes: Tokens are eight bits wide with a separate control flag.
// Notes:   Register counts are local choices of this block.
`ifndef CRA_MAP_VH
`define CRA_MAP_VH
`define CRA_TOK_WR      8'hC0
`define CRA_TOK_RD      8'hC1
`define CRA_TOK_PRD     8'h25
`define CRA_TOK_PWR     8'h24
`define CRA_TOK_END     8'h01
`define CRA_TOK_ACK     8'h03
`define CRA_TOK_NAK     8'h04
`define CRA_DST_TILE    16'hC20C
`define CRA_DST_NODE    16'hC30C
`define CRA_DST_PER     8'h02
`define CRA_CFG_REGS    16'h0010
`define CRA_CFG_AW      4
`define CRA_PER_BYTES   9'h010
`define CRA_PER_AW      4
`define CRA_RID_LAST    8'h02
`define CRA_WORD_LAST   8'h03
`define CRA_WORD_BYTES  8'h04
`define CRA_KIND_WR     2'h0
`define CRA_KIND_RD     2'h1
`define CRA_KIND_PRD    2'h2
`define CRA_KIND_PWR    2'h3
`endif

// ===== rtl/cra_resp_tx.v
// Purpose: Sends one reply: status token, optional data bytes, end token.
// Assumes: byteIn follows byteIdx combinationally and stays still while busy.
// Notes:   Data bytes are fetched one token ahead of their transmission.
`timescale 1ns/1ps
`include "cra_map.vh"
module cra_resp_tx (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rst,
	// Reply request
	input  wire       start,
	input  wire       okFlag,
	input  wire [7:0] dataCnt,
	output wire [7:0] byteIdx,
	input  wire [7:0] byteIn,
	output wire       busy,
	// Token output
	output wire       outValid,
	input  wire       outReady,
	output wire [7:0] outData,
	output wire       outCtrl
);
	localparam T_IDLE = 2'h0;
	localparam T_HEAD = 2'h1;
	localparam T_DATA = 2'h2;
	localparam T_TAIL = 2'h3;

	reg [1:0] state_r;
	reg [7:0] cnt_r;
	reg [7:0] data_r;
	reg       ctrl_r;
	wire      fire;

	assign fire     = outValid && outReady;
	assign outValid = (state_r != T_IDLE);
	assign busy     = outValid;
	assign byteIdx  = cnt_r;
	assign outData  = data_r;
	assign outCtrl  = ctrl_r;

	always @(posedge clk_sys) begin
		if (rst) begin
			state_r <= T_IDLE;
			cnt_r   <= 8'h00;
			data_r  <= 8'h00;
			ctrl_r  <= 1'b0;
		end else begin
			case (state_r)
			T_IDLE: begin
				if (start) begin
					state_r <= T_HEAD;
					cnt_r   <= 8'h00;
					ctrl_r  <= 1'b1;
					data_r  <= okFlag ? `CRA_TOK_ACK : `CRA_TOK_NAK;
				end
			end
			T_HEAD: begin
				if (fire) begin
					if (okFlag && dataCnt != 8'h00) begin
						state_r <= T_DATA;
						data_r  <= byteIn;
						ctrl_r  <= 1'b0;
						cnt_r   <= cnt_r + 8'h01;
					end else begin
						state_r <= T_TAIL;
						data_r  <= `CRA_TOK_END;
						ctrl_r  <= 1'b1;
					end
				end
			end
			T_DATA: begin
				if (fire) begin
					if (cnt_r == dataCnt) begin
						state_r <= T_TAIL;
						data_r  <= `CRA_TOK_END;
						ctrl_r  <= 1'b1;
					end else begin
						data_r  <= byteIn;
						cnt_r   <= cnt_r + 8'h01;
					end
				end
			end
			T_TAIL: begin
				if (fire) begin
					state_r <= T_IDLE;
					ctrl_r  <= 1'b0;
				end
			end
			default: begin
				state_r <= T_IDLE;
			end
			endcase
		end
	end
endmodule

// ===== testbench/cra_responder_sva.sv
// Purpose: Reply-port assertions for the config responder.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to every cra_responder instance.
`timescale 1ns/1ps
`include "cra_map.vh"
module cra_responder_sva (
	// Clock and reset
	input wire        clk_sys,
	input wire        rst,
	// Request side
	input wire        inValid,
	input wire        inReady,
	input wire [7:0]  inData,
	input wire        inCtrl,
	input wire [31:0] chanDest,
	// Reply side
	input wire        outValid,
	input wire        outReady,
	input wire [7:0]  outData,
	input wire        outCtrl,
	input wire [23:0] outDest
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire endTok = inValid && inReady && inCtrl && inData == `CRA_TOK_END;
	wire outFire = outValid && outReady;
	AST_HOLD: assert property (outValid && !outReady |=>
		outValid && $stable({outCtrl, outData})) else $error("Token moved.");
	AST_STATUS: assert property ($rose(outValid) |-> outCtrl &&
		(outData == `CRA_TOK_ACK || outData == `CRA_TOK_NAK))
		else $error("Reply does not open with a status token.");
	AST_CAUSE: assert property ($rose(outValid) |-> $past(endTok, 2))
		else $error("Reply not two edges after an end token.");
	AST_BUSY: assert property (outValid |-> !inReady)
		else $error("Request taken during a reply.");
	AST_NAK: assert property (outFire && outCtrl &&
		outData == `CRA_TOK_NAK |=> outValid && outCtrl &&
		outData == `CRA_TOK_END) else $error("Failure not closed by end.");
	AST_DROP: assert property (outFire && outCtrl &&
		outData == `CRA_TOK_END |=> !outValid)
		else $error("Reply runs past its end token.");
	AST_DATA: assert property (outFire && !outCtrl |=> outValid)
		else $error("Reply stopped after a data byte.");
	AST_DEST: assert property (outValid && $past(outValid) |->
		$stable(outDest)) else $error("Return id moved mid-reply.");
	COV_ACK: cover property ($rose(outValid) && outData == `CRA_TOK_ACK);
	COV_NAK: cover property ($rose(outValid) && outData == `CRA_TOK_NAK);
	COV_STALL: cover property (outValid && !outReady);
endmodule
bind cra_responder cra_responder_sva u_sva (.clk_sys(clk_sys), .rst(rst),
	.inValid(inValid), .inReady(inReady), .inData(inData),
	.inCtrl(inCtrl), .chanDest(chanDest), .outValid(outValid),
	.outReady(outReady), .outData(outData), .outCtrl(outCtrl),
	.outDest(outDest));

// ===== testbench/cra_chan_sink.sv
// Purpose: Requesting channel end that collects reply tokens.
// Assumes: Replies arrive on clk_sys with a valid/ready handshake.
// Notes:   Slow mode drops ready every other cycle to stall the sender.
`timescale 1ns/1ps
module cra_chan_sink (
	// Clock and reset
	input wire        clk_sys,
	input wire        rst,
	// Reply tokens
	input wire        outValid,
	input wire [7:0]  outData,
	input wire        outCtrl,
	input wire [23:0] outDest,
	// Pacing
	input wire        slow,
	output wire       outReady
);
	reg          readyT_r;
	logic [8:0]  got [0:63];
	logic [23:0] dst [0:63];
	int          gotCnt;
	assign outReady = !slow || readyT_r;
	always @(posedge clk_sys) begin
		if (rst) begin
			readyT_r <= 1'b0;
			gotCnt <= 0;
		end else begin
			readyT_r <= !readyT_r;
			if (outValid && outReady) begin
				got[gotCnt] <= {outCtrl, outData};
				dst[gotCnt] <= outDest;
				gotCnt <= gotCnt + 1;
			end
		end
	end
endmodule

// ===== testbench/cra_responder_bench.sv
// Purpose: Self-checking bench for the config responder.
// Assumes: Tokens are {ctrl, byte}; replies gathered by the sink model.
// Notes:   Register contents are not reset, so reads follow writes.
`timescale 1ns/1ps
module cra_responder_bench;
	logic        clk_sys, rst, inValid, inCtrl, slow;
	logic [7:0]  inData;
	logic [31:0] chanDest;
	wire         inReady, outValid, outReady, outCtrl;
	wire  [7:0]  outData;
	wire  [23:0] outDest;
	int          fail_count, cmp_count;
	cra_responder DUT (.clk_sys(clk_sys), .rst(rst), .inValid(inValid),
		.inReady(inReady), .inData(inData), .inCtrl(inCtrl),
		.chanDest(chanDest), .outValid(outValid), .outReady(outReady),
		.outData(outData), .outCtrl(outCtrl), .outDest(outDest));
	cra_chan_sink mdl (.clk_sys(clk_sys), .rst(rst), .outValid(outValid),
		.outData(outData), .outCtrl(outCtrl), .outDest(outDest),
		.slow(slow), .outReady(outReady));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Held until the edge that samples inReady high.
	task tok(input logic [8:0] d);
		int n;
		{inCtrl, inData} = d;
		inValid = 1'b1;
		n = 0;
		@(negedge clk_sys);
		while (inReady !== 1'b1) begin
			@(negedge clk_sys);
			n++;
			if (n > 60) begin
				fail_count++;
				test_done;
			end
		end
		@(posedge clk_sys);
		#1;
	endtask
	task run(input logic [31:0] d, input logic [8:0] rq[$],
		input logic [8:0] ex[$]);
		int b, n;
		@(posedge clk_sys);
		#1;
		b = mdl.gotCnt;
		chanDest = d;
		foreach (rq[i]) tok(rq[i]);
		inValid = 1'b0;
		inData = ~inData;
		n = 0;
		while (mdl.gotCnt < b + ex.size()) begin
			@(negedge clk_sys);
			n++;
			if (n > 200) begin
				fail_count++;
				test_done;
			end
		end
		foreach (ex[i]) chk("reply token", mdl.got[b + i], ex[i]);
		chk("reply id", mdl.dst[b], {rq[1][7:0], rq[2][7:0], rq[3][7:0]});
	endtask
	task t_tile;
		run(32'h0003C20C, '{9'h1C0, 9'h012, 9'h034, 9'h056, 9'h000, 9'h005,
			9'h0DE, 9'h0AD, 9'h0BE, 9'h0EF, 9'h101}, '{9'h103, 9'h101});
		run(32'h0003C20C, '{9'h1C1, 9'h0A1, 9'h0A2, 9'h0A3, 9'h000, 9'h005,
			9'h101}, '{9'h103, 9'h0DE, 9'h0AD, 9'h0BE, 9'h0EF, 9'h101});
		$display("tile test done");
	endtask
	task t_node;
		run(32'hABCDC30C, '{9'h1C0, 9'h0C1, 9'h0C2, 9'h0C3, 9'h000, 9'h00F,
			9'h001, 9'h002, 9'h003, 9'h004, 9'h101}, '{9'h103, 9'h101});
		run(32'hABCDC30C, '{9'h1C1, 9'h0C4, 9'h0C5, 9'h0C6, 9'h000, 9'h00F,
			9'h101}, '{9'h103, 9'h001, 9'h002, 9'h003, 9'h004, 9'h101});
		run(32'hABCDC30C, '{9'h1C1, 9'h0C1, 9'h0C2, 9'h0C3, 9'h000, 9'h010,
			9'h101}, '{9'h104, 9'h101});
		$display("node test done");
	endtask
	task t_per;
		slow = 1'b1;
		run(32'h00120702, '{9'h124, 9'h011, 9'h022, 9'h033, 9'h002, 9'h002,
			9'h0AA, 9'h0BB, 9'h101}, '{9'h103, 9'h101});
		run(32'h00120702, '{9'h125, 9'h011, 9'h022, 9'h033, 9'h002, 9'h002,
			9'h101}, '{9'h103, 9'h0AA, 9'h0BB, 9'h101});
		run(32'h00120702, '{9'h125, 9'h011, 9'h022, 9'h033, 9'h002, 9'h000,
			9'h101}, '{9'h104, 9'h101});
		slow = 1'b0;
		$display("peripheral test done");
	endtask
	task t_bad;
		run(32'h00120702, '{9'h1C0, 9'h044, 9'h055, 9'h066, 9'h000, 9'h005,
			9'h001, 9'h002, 9'h003, 9'h004, 9'h101}, '{9'h104, 9'h101});
		// A refused write must leave the earlier word in place.
		run(32'h0003C20C, '{9'h1C1, 9'h0B1, 9'h0B2, 9'h0B3, 9'h000, 9'h005,
			9'h101}, '{9'h103, 9'h0DE, 9'h0AD, 9'h0BE, 9'h0EF, 9'h101});
		run(32'h0003C20C, '{9'h1C1, 9'h077, 9'h088, 9'h099, 9'h001,
			9'h101}, '{9'h104, 9'h101});
		run(32'h0003C20C, '{9'h1C1, 9'h0B4, 9'h0B5, 9'h0B6, 9'h000, 9'h005,
			9'h077, 9'h101}, '{9'h104, 9'h101});
		run(32'h0003C20C, '{9'h1C1, 9'h0B7, 9'h0B8, 9'h0B9, 9'h103, 9'h0AA,
			9'h101}, '{9'h104, 9'h101});
		$display("bad request test done");
	endtask
	initial begin
		fail_count = 0;
		cmp_count = 0;
		inValid = 1'b0;
		inCtrl = 1'b0;
		inData = 8'h00;
		chanDest = 32'h00000000;
		slow = 1'b0;
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		t_tile;
		t_node;
		t_per;
		t_bad;
		test_done;
	end
endmodule
